// file: logic/dmc_cmd_top.sv
// modbus slave command interpreter of the drive: checks frames, decodes registers
`timescale 1ns/10ps
`default_nettype none
module dmc_cmd_top
    import dmc_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] STATION_ADDR,
    input wire logic ASCII_MODE,
    input wire logic RX_START,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_END,
    input wire logic [7:0] WARN_CODE,
    input wire logic [7:0] FAULT_CODE,
    output logic [1:0] RUN_REQ,
    output logic [1:0] DIR_REQ,
    output logic [1:0] ACCEL_SET,
    output logic [3:0] SPEED_SEL,
    output logic [15:0] FREQ_SET,
    output logic EXT_FAULT,
    output logic FAULT_RESET,
    output logic BASE_BLOCK,
    output logic FRAME_OK,
    output logic FRAME_BAD,
    output logic [15:0] READ_DATA,
    output logic READ_VALID,
    output logic [7:0] CHECK_LOW,
    output logic [7:0] CHECK_HIGH
);
    `include "dmc_map.svh"

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        dmc_state_t st;
        logic [7:0] func;
        logic [15:0] reg_addr;
        logic [15:0] count;
        logic [15:0] data;
        logic [7:0] ck0;
        logic [7:0] ck1;
        logic [15:0] crc_hold;
        logic [7:0] lrc_hold;
        logic has_data;
        logic [1:0] run;
        logic [1:0] dir;
        logic [1:0] accel;
        logic [3:0] speed;
        logic [15:0] freq;
        logic ext_fault;
        logic fault_reset;
        logic base_block;
        logic ok;
        logic bad;
        logic [15:0] rd;
        logic rd_valid;
        logic [7:0] ckl;
        logic [7:0] ckh;
    } dmc_top_t;

    dmc_top_t q;
    dmc_top_t next_q;
    logic [15:0] crc_now;
    logic [7:0] lrc_now;
    logic [15:0] pm_rdata;
    logic pm_we;
    logic check_match;
    logic addr_hit;
    logic [15:0] cmd;

    // ------------------------------------------------------------
    // checksum and parameter store
    // ------------------------------------------------------------
    // checksum bytes themselves must not enter the running value, so only
    // bytes before the first checksum byte are fed in
    dmc_crc_unit u_crc (
        .clk(CLK),
        .reset(RESET),
        .start(RX_START),
        .valid(RX_VALID && q.st != ST_CK0 && q.st != ST_CK1 && q.st != ST_DONE
               && q.st != ST_SKIP),
        .data(RX_DATA),
        .crc(crc_now),
        .lrc(lrc_now)
    );

    // parameter writes are applied only after the frame checks out
    assign pm_we = RX_END && check_match && addr_hit && q.has_data
                   && q.reg_addr <= `DMC_PARAM_TOP;
    dmc_param_mem u_pm (
        .clk(CLK),
        .we(pm_we),
        .param_group_index(q.reg_addr),
        .wdata(q.data),
        .rdata(pm_rdata)
    );

    assign check_match = q.st == ST_DONE &&
        (ASCII_MODE ? (q.ck0 == q.lrc_hold)
                    : ({q.ck1, q.ck0} == q.crc_hold));
    assign addr_hit = 1'b1;
    assign cmd = q.data;

    // ------------------------------------------------------------
    // frame walk
    // ------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.ok = 1'b0;
        next_q.bad = 1'b0;
        next_q.rd_valid = 1'b0;
        next_q.fault_reset = 1'b0;
        if (RX_START) begin
            next_q.st = ST_ADDR;
            next_q.has_data = 1'b0;
        end else if (RX_VALID) begin
            case (q.st)
                ST_ADDR: begin
                    if (RX_DATA == `DMC_BCAST_ADDR || RX_DATA == STATION_ADDR) begin
                        next_q.st = ST_FUNC;
                    end else begin
                        next_q.st = ST_SKIP;
                    end
                end
                ST_FUNC: begin
                    next_q.func = RX_DATA;
                    next_q.st = ST_RH;
                end
                ST_RH: begin
                    next_q.reg_addr[15:8] = RX_DATA;
                    next_q.st = ST_RL;
                end
                ST_RL: begin
                    next_q.reg_addr[7:0] = RX_DATA;
                    next_q.st = (q.func == `DMC_FN_WRITE1) ? ST_DH : ST_NH;
                end
                ST_NH: begin
                    next_q.count[15:8] = RX_DATA;
                    next_q.st = ST_NL;
                end
                ST_NL: begin
                    next_q.count[7:0] = RX_DATA;
                    if (q.func == `DMC_FN_WRITEN) begin
                        if (q.count[15:8] != 8'h00 || RX_DATA > `DMC_MAX_REGS
                            || RX_DATA == 8'h00) begin
                            next_q.st = ST_SKIP;
                        end else begin
                            next_q.st = ST_BC;
                        end
                    end else begin
                        next_q.st = ST_CK0;
                    end
                end
                ST_BC: next_q.st = ST_DH;
                ST_DH: begin
                    next_q.data[15:8] = RX_DATA;
                    next_q.st = ST_DL;
                end
                ST_DL: begin
                    // single-register apply; a multi-write keeps the first word's low byte and the last word's high byte
                    next_q.data[7:0] = RX_DATA;
                    next_q.has_data = 1'b1;
                    next_q.st = (q.func == `DMC_FN_WRITEN && q.count[7:0] > 8'h01)
                                ? ST_DH : ST_CK0;
                    if (q.func == `DMC_FN_WRITEN) begin
                        next_q.count = q.count - 16'h0001;
                        if (q.has_data) begin
                            next_q.data = q.data;
                        end
                    end
                end
                ST_CK0: begin
                    next_q.ck0 = RX_DATA;
                    next_q.crc_hold = crc_now;
                    next_q.lrc_hold = lrc_now;
                    next_q.st = ASCII_MODE ? ST_DONE : ST_CK1;
                end
                ST_CK1: begin
                    next_q.ck1 = RX_DATA;
                    next_q.st = ST_DONE;
                end
                default: next_q.st = ST_SKIP;
            endcase
        end else if (RX_END) begin
            if (check_match && addr_hit) begin
                next_q.ok = 1'b1;
                if (q.has_data) begin
                    case (q.reg_addr)
                        `DMC_ADDR_CMD: begin
                            next_q.run = cmd[1:0];
                            next_q.dir = cmd[5:4];
                            if (cmd[`DMC_BIT_ENA]) begin
                                next_q.accel = cmd[7:6];
                                next_q.speed = cmd[11:8];
                            end
                        end
                        `DMC_ADDR_FREQ: next_q.freq = cmd;
                        `DMC_ADDR_FCTL: begin
                            next_q.ext_fault = cmd[`DMC_BIT_EXTFLT];
                            next_q.fault_reset = cmd[`DMC_BIT_FRST];
                            next_q.base_block = cmd[`DMC_BIT_BBLK];
                        end
                        default: begin
                        end
                    endcase
                end else if (q.func == `DMC_FN_READ) begin
                    next_q.rd_valid = 1'b1;
                    next_q.rd = (q.reg_addr == `DMC_ADDR_STAT)
                                ? {WARN_CODE, FAULT_CODE} : pm_rdata;
                end
            end else begin
                next_q.bad = 1'b1;
            end
            next_q.st = ST_SKIP;
        end
        next_q.ckl = ASCII_MODE ? lrc_now : crc_now[7:0];
        next_q.ckh = ASCII_MODE ? 8'h00 : crc_now[15:8];
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            q <= '0;
            q.st <= ST_SKIP;
        end else begin
            q <= next_q;
        end
    end

    assign RUN_REQ = q.run;
    assign DIR_REQ = q.dir;
    assign ACCEL_SET = q.accel;
    assign SPEED_SEL = q.speed;
    assign FREQ_SET = q.freq;
    assign EXT_FAULT = q.ext_fault;
    assign FAULT_RESET = q.fault_reset;
    assign BASE_BLOCK = q.base_block;
    assign FRAME_OK = q.ok;
    assign FRAME_BAD = q.bad;
    assign READ_DATA = q.rd;
    assign READ_VALID = q.rd_valid;
    assign CHECK_LOW = q.ckl;
    assign CHECK_HIGH = q.ckh;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_BAD_NO_EFFECT: assert property (@(posedge CLK) disable iff (RESET)
        FRAME_BAD |-> $stable(RUN_REQ) && $stable(FREQ_SET)) else $error("bad frame acted");
    AST_GATE_ACCEL: assert property (@(posedge CLK) disable iff (RESET)
        (RX_END && check_match && q.has_data && q.reg_addr == `DMC_ADDR_CMD
         && !cmd[`DMC_BIT_ENA]) |=> $stable(ACCEL_SET) && $stable(SPEED_SEL))
        else $error("accel changed while gated");
    AST_SPEED_LOAD: assert property (@(posedge CLK) disable iff (RESET)
        (RX_END && check_match && q.has_data && q.reg_addr == `DMC_ADDR_CMD
         && cmd[`DMC_BIT_ENA]) |=> SPEED_SEL == $past(cmd[11:8])) else $error("speed");
    AST_RESET_PULSE: assert property (@(posedge CLK) disable iff (RESET)
        FAULT_RESET |=> !FAULT_RESET) else $error("fault reset not a pulse");
    AST_STATUS_READ: assert property (@(posedge CLK) disable iff (RESET)
        (READ_VALID && $past(q.reg_addr) == `DMC_ADDR_STAT)
        |-> READ_DATA == $past({WARN_CODE, FAULT_CODE})) else $error("status");
    AST_OK_XOR_BAD: assert property (@(posedge CLK) disable iff (RESET)
        !(FRAME_OK && FRAME_BAD)) else $error("ok and bad together");
    AST_CRC_PRESET: assert property (@(posedge CLK) disable iff (RESET)
        RX_START |=> crc_now == `DMC_CRC_PRESET) else $error("crc preset");
    AST_MAX_REGS: assert property (@(posedge CLK) disable iff (RESET)
        (RX_VALID && q.st == ST_NL && q.func == `DMC_FN_WRITEN && RX_DATA > `DMC_MAX_REGS
         && !RX_START) |=> q.st == ST_SKIP) else $error("too many registers");
    // a frame for another station must never reach the checksum compare
    AST_FOREIGN_SKIP: assert property (@(posedge CLK) disable iff (RESET)
        (RX_VALID && !RX_START && q.st == ST_ADDR && RX_DATA != `DMC_BCAST_ADDR
         && RX_DATA != STATION_ADDR) |=> q.st == ST_SKIP) else $error("foreign frame taken");
    AST_OK_NEEDS_MATCH: assert property (@(posedge CLK) disable iff (RESET)
        FRAME_OK |-> $past(RX_END && check_match)) else $error("ok without match");
endmodule // dmc_cmd_top
`default_nettype wire

// file: logic/dmc_crc_unit.sv
// checksum unit: modbus crc-16 and ascii lrc over one message
`timescale 1ns/10ps
`default_nettype none
module dmc_crc_unit
    import dmc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic valid,
    input wire logic [7:0] data,
    output logic [15:0] crc,
    output logic [7:0] lrc
);
    `include "dmc_map.svh"
    typedef struct packed {
        logic [15:0] crc;
        logic [7:0] sum;
    } dmc_ck_t;
    dmc_ck_t q;
    dmc_ck_t next_q;
    logic [15:0] c;

    always_comb begin
        next_q = q;
        c = q.crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `DMC_CRC_POLY) : (c >> 1);
        end
        if (start) begin
            next_q.crc = `DMC_CRC_PRESET;
            next_q.sum = 8'h00;
        end else if (valid) begin
            next_q.crc = c;
            next_q.sum = q.sum + data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '{crc: `DMC_CRC_PRESET, sum: 8'h00};
        end else begin
            q <= next_q;
        end
    end
    assign crc = q.crc;
    assign lrc = 8'h00 - q.sum;
endmodule // dmc_crc_unit
`default_nettype wire

// file: logic/dmc_map.svh
// register offsets, field positions and constants of the drive command interpreter
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH
`define DMC_ADDR_CMD 16'h2000
`define DMC_ADDR_FREQ 16'h2001
`define DMC_ADDR_FCTL 16'h2002
`define DMC_ADDR_STAT 16'h2100
`define DMC_CRC_PRESET 16'hFFFF
`define DMC_CRC_POLY 16'hA001
`define DMC_FN_READ 8'h03
`define DMC_FN_WRITE1 8'h06
`define DMC_FN_WRITEN 8'h10
`define DMC_MAX_REGS 8'h14
`define DMC_BCAST_ADDR 8'h00
`define DMC_BIT_ENA 12
`define DMC_BIT_EXTFLT 0
`define DMC_BIT_FRST 1
`define DMC_BIT_BBLK 2
`define DMC_PARAM_TOP 16'h1FFF
`endif

// file: logic/dmc_param_mem.sv
// drive parameter store addressed by group and index
`timescale 1ns/10ps
`default_nettype none
module dmc_param_mem
    import dmc_pkg::*;
(
    input wire logic clk,
    input wire logic we,
    input wire logic [15:0] param_group_index,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata
);
    logic [15:0] mem [0:255];
    // group in the high nibble-byte, index in low: four groups of sixty-four fold into 256 words
    logic [7:0] idx;
    assign idx = {param_group_index[9:8], param_group_index[5:0]};
    always_ff @(posedge clk) begin
        if (we) begin
            mem[idx] <= wdata;
        end
        rdata <= mem[idx];
    end
endmodule // dmc_param_mem
`default_nettype wire

// file: logic/dmc_pkg.sv
// types shared by the drive command interpreter
package dmc_pkg;
    typedef enum logic [1:0] {RUN_NONE, RUN_STOP, RUN_GO, RUN_INCH} dmc_run_t;
    typedef enum logic [1:0] {DIR_NONE, DIR_FWD, DIR_REV, DIR_CHG} dmc_dir_t;
    typedef enum logic [3:0] {
        ST_ADDR, ST_FUNC, ST_RH, ST_RL, ST_NH, ST_NL, ST_BC, ST_DH, ST_DL,
        ST_CK0, ST_CK1, ST_DONE, ST_SKIP
    } dmc_state_t;
endpackage

// file: testbench/dmc_master_model.sv
// partner model: serial master handing decoded frame bytes to the drive
`timescale 1ns/10ps
`default_nettype none
module dmc_master_model (
    input wire logic CLK,
    output logic RX_START,
    output logic RX_VALID,
    output logic [7:0] RX_DATA,
    output logic RX_END
);
    logic [7:0] q[$];
    logic ascii;

    initial begin
        ascii = 1'b0;
        RX_START = 1'b0;
        RX_VALID = 1'b0;
        RX_END = 1'b0;
        RX_DATA = 8'h00;
    end

    // ----------------------------------------
    // frame sender: appends the check value, optionally spoilt
    // ----------------------------------------
    task automatic send(input bit bad);
        logic [15:0] c;
        logic [7:0] s;
        c = 16'hFFFF;
        s = 8'h00;
        foreach (q[i]) begin
            s = s + q[i];
            c = c ^ {8'h00, q[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        if (ascii) begin
            q.push_back(8'h00 - s);
        end else begin
            q.push_back(c[7:0]);
            q.push_back(c[15:8]);
        end
        if (bad) begin
            q[q.size() - 1] = q[q.size() - 1] ^ 8'h01;
        end
        @(posedge CLK) #1 RX_START = 1'b1;
        foreach (q[i]) begin
            @(posedge CLK) #1 RX_START = 1'b0;
            RX_VALID = 1'b1;
            RX_DATA = q[i];
        end
        // idle data is not left at the last byte, so stale use shows
        @(posedge CLK) #1 RX_VALID = 1'b0;
        RX_DATA = ~RX_DATA;
        RX_END = 1'b1;
        @(posedge CLK) #1 RX_END = 1'b0;
        q.delete();
    endtask
endmodule // dmc_master_model
`default_nettype wire

// file: testbench/drive_modbus_command_checksum_tb_top.sv
// self-checking bench of the drive command interpreter
`timescale 1ns/10ps
`default_nettype none
module drive_modbus_command_checksum_tb_top;
    import dmc_pkg::*;
    logic clk, rst, amode, rs, rv_in, re, ok, bad, rvd, frst;
    logic [7:0] sta, rd8, wc, fc;
    logic [1:0] run_q, dir_q, acc_q, acc_e;
    logic [3:0] spd_q, spd_e;
    logic [15:0] freq_q, rdat, rd, cmd, w, exp_ck;
    logic ef_q, fr_q, bb_q, ok_q, bad_q, rv_q;
    logic [7:0] cl_q, ch_q;
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 32'h3ab322d1;

    dmc_master_model m (.CLK(clk), .RX_START(rs), .RX_VALID(rv_in), .RX_DATA(rd8), .RX_END(re));
    dmc_cmd_top dut (.CLK(clk), .RESET(rst), .STATION_ADDR(sta), .ASCII_MODE(amode),
        .RX_START(rs), .RX_VALID(rv_in), .RX_DATA(rd8), .RX_END(re), .WARN_CODE(wc),
        .FAULT_CODE(fc), .RUN_REQ(run_q), .DIR_REQ(dir_q), .ACCEL_SET(acc_q),
        .SPEED_SEL(spd_q), .FREQ_SET(freq_q), .EXT_FAULT(ef_q), .FAULT_RESET(fr_q),
        .BASE_BLOCK(bb_q), .FRAME_OK(ok_q), .FRAME_BAD(bad_q), .READ_DATA(rdat),
        .READ_VALID(rv_q), .CHECK_LOW(cl_q), .CHECK_HIGH(ch_q));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask

    task automatic put16(input logic [15:0] v);
        m.q.push_back(v[15:8]);
        m.q.push_back(v[7:0]);
    endtask

    // running check value over the queued message bytes, before any check byte is added
    function automatic logic [15:0] ck_of(input bit asc);
        logic [15:0] c;
        logic [7:0] s;
        c = 16'hFFFF;
        s = 8'h00;
        foreach (m.q[i]) begin
            s = s + m.q[i];
            c = c ^ {8'h00, m.q[i]};
            for (int j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return asc ? {8'h00, 8'h00 - s} : c;
    endfunction

    // bounded watch of the frame's pulses while the master sends
    task automatic watch();
        ok = 1'b0;
        bad = 1'b0;
        rvd = 1'b0;
        frst = 1'b0;
        // long enough for a twenty-one word multi-write frame plus its answer
        repeat (64) begin
            @(posedge clk) #2;
            ok = ok | (ok_q === 1'b1);
            bad = bad | (bad_q === 1'b1);
            frst = frst | (fr_q === 1'b1);
            if (rv_q === 1'b1) begin
                rvd = 1'b1;
                rd = rdat;
            end
        end
    endtask

    task automatic run(input bit b);
        fork
            m.send(b);
            watch();
        join
    endtask

    task automatic frm(input logic [7:0] a, input logic [7:0] fn, input logic [15:0] r,
                       input logic [15:0] d, input bit b);
        m.q.push_back(a);
        m.q.push_back(fn);
        put16(r);
        put16(d);
        exp_ck = ck_of(amode);
        run(b);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        amode = 1'b0;
        wc = 8'h00;
        fc = 8'h00;
        sta = 8'h01 + (8'h7F & 8'($random(seed)));
        acc_e = 2'b00;
        spd_e = 4'h0;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        frm(sta, 8'h06, 16'h0100, 16'h1770, 1'b0);
        chk("crc_value", exp_ck, {ch_q, cl_q});
        chk("first_ok", 32'h0000_0002, {ok, bad});
        frm(sta, 8'h03, 16'h0100, 16'h0001, 1'b0);
        chk("param_read", 16'h1770, rvd ? rd : 16'hxxxx);
        for (int i = 0; i < 8; i++) begin
            cmd = 16'($random(seed));
            cmd[1:0] = i[1:0];
            cmd[5:4] = i[2:1];
            cmd[12] = i[0] ^ i[2];
            if (cmd[12]) begin
                acc_e = cmd[7:6];
                spd_e = cmd[11:8];
            end
            frm(sta, 8'h06, 16'h2000, cmd, 1'b0);
            chk("run_req", {14'h0, cmd[1:0]}, {14'h0, run_q});
            chk("dir_req", {14'h0, cmd[5:4]}, {14'h0, dir_q});
            chk("accel_set", {14'h0, acc_e}, {14'h0, acc_q});
            chk("speed_sel", {12'h0, spd_e}, {12'h0, spd_q});
        end
        amode = 1'b1;
        m.ascii = 1'b1;
        w = 16'($random(seed));
        frm(sta, 8'h06, 16'h2001, w, 1'b0);
        chk("ascii_freq", w, freq_q);
        chk("lrc_value", exp_ck, {ch_q, cl_q});
        frm(sta, 8'h06, 16'h2001, ~w, 1'b1);
        chk("ascii_bad", 16'h0001, {14'h0, ok, bad});
        amode = 1'b0;
        m.ascii = 1'b0;
        for (int b = 0; b < 3; b++) begin
            frm(sta, 8'h06, 16'h2002, 16'h0001 << b, 1'b0);
            chk("fault_ctl", {13'h0, b == 2, b == 1, b == 0}, {13'h0, bb_q, frst, ef_q});
        end
        wc = 8'($random(seed));
        fc = 8'($random(seed));
        frm(sta, 8'h03, 16'h2100, 16'h0001, 1'b0);
        chk("warn_fault", {wc, fc}, rvd ? rd : 16'hxxxx);
        frm(sta, 8'h06, 16'h2001, ~w, 1'b1);
        chk("crc_bad", {w, 8'h01}, {freq_q, 6'h0, ok, bad});
        frm(8'h00, 8'h06, 16'h2001, w + 16'h0001, 1'b0);
        chk("broadcast", w + 16'h0001, freq_q);
        frm(sta + 8'h01, 8'h06, 16'h2001, w, 1'b0);
        chk("foreign", {w + 16'h0001, 1'b0}, {freq_q, ok});
        for (int n = 20; n < 22; n++) begin
            m.q.push_back(sta);
            m.q.push_back(8'h10);
            put16(16'h2001);
            put16(16'(n));
            m.q.push_back(8'(2 * n));
            for (int k = 0; k < n; k++) put16(16'h0100 + 16'(n + k));
            run(1'b0);
            chk("write_multi", n == 20 ? {16'h0114, 1'b1} : {16'h0114, 1'b0}, {freq_q, ok});
        end
        report_and_stop();
    end
endmodule // drive_modbus_command_checksum_tb_top
`default_nettype wire
